// File: hdl/periph_intx_consts.vh
`ifndef PERIPH_INTX_CONSTS_VH
`define PERIPH_INTX_CONSTS_VH

// ----------------------------------------------------------------------------
// Source slots: index into the 17-entry source table, ordered by priority.
// ----------------------------------------------------------------------------
`define NUM_SRC          17
`define SLOT_T2_PERIOD   0
`define SLOT_T2_COMPARE  1
`define SLOT_T2_UNDER    2
`define SLOT_T2_OVER     3
`define SLOT_T4_PERIOD   4
`define SLOT_T4_COMPARE  5
`define SLOT_T4_UNDER    6
`define SLOT_T4_OVER     7
`define SLOT_SPP         8
`define SLOT_ARX         9
`define SLOT_ATX         10
`define SLOT_CAN_MB      11
`define SLOT_CAN_ERR     12
`define SLOT_EXT_A       13
`define SLOT_EXT_B       14

// ----------------------------------------------------------------------------
// Overall priorities.
// ----------------------------------------------------------------------------
`define PRI_T2_PERIOD    6'd28
`define PRI_T4_PERIOD    6'd32
`define PRI_SPP          6'd42
`define PRI_ARX          6'd43
`define PRI_ATX          6'd44
`define PRI_CAN_MB       6'd45
`define PRI_CAN_ERR      6'd46
`define PRI_EXT_A        6'd48
`define PRI_EXT_B        6'd49

// ----------------------------------------------------------------------------
// Request and acknowledge bit positions, group 0/1/2 of 16 bits each.
// ----------------------------------------------------------------------------
`define BIT_T2_PERIOD    4'h0
`define BIT_T4_PERIOD    4'h8
`define BIT_SPP          4'h7
`define BIT_ARX          4'h8
`define BIT_ATX          4'h9
`define BIT_CAN_MB       4'hA
`define BIT_CAN_ERR      4'hB
`define BIT_EXT_A        4'hD
`define BIT_EXT_B        4'hE
`define BIT_HP_EXT_A     4'h2
`define BIT_HP_EXT_B     4'h3
`define BIT_HP_SPP       4'h4
`define BIT_HP_ARX       4'h5
`define BIT_HP_ATX       4'h6
`define BIT_HP_CAN_MB    4'h7
`define BIT_HP_CAN_ERR   4'h8

// ----------------------------------------------------------------------------
// Peripheral vector codes.
// ----------------------------------------------------------------------------
`define VEC_PHANTOM      16'h0000
`define VEC_T2_PERIOD    16'h002B
`define VEC_T4_PERIOD    16'h0039
`define VEC_SPP          16'h0005
`define VEC_ARX          16'h0006
`define VEC_ATX          16'h0007
`define VEC_CAN_MB       16'h0040
`define VEC_CAN_ERR      16'h0041
`define VEC_EXT_A        16'h0001
`define VEC_EXT_B        16'h0011

// ----------------------------------------------------------------------------
// CPU vector addresses and reserved software ranges.
// ----------------------------------------------------------------------------
`define ADDR_LEVEL_ONE   16'h0002
`define ADDR_LEVEL_THREE 16'h0006
`define ADDR_LEVEL_FIVE  16'h000A
`define ADDR_LEVEL_SIX   16'h000C
`define ADDR_SWL_LO      16'h0010
`define ADDR_SWL_HI      16'h0020
`define ADDR_SWI_LO      16'h0028
`define ADDR_SWI_HI      16'h003F

`endif

// File: hdl/prio_pick.v
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Picks the lowest-numbered set bit of a request vector.
// ----------------------------------------------------------------------------
module prio_pick
#(
  parameter N  = 17,
  parameter IW = 5
)
(
  // Requests, bit 0 is the most urgent.
  input  wire [N-1:0]  reqVec,
  // Result.
  output reg           anyReq,
  output reg  [IW-1:0] winIdx
);

  integer k;

  always @*
  begin
    anyReq = 1'b0;
    winIdx = {IW{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1)
    begin
      if (reqVec[k])
      begin
        anyReq = 1'b1;
        winIdx = k[IW-1:0];
      end
    end
  end

endmodule // prio_pick

// File: hdl/periph_interrupt_expander.v
`timescale 1ns/100ps
`include "periph_intx_consts.vh"

module periph_interrupt_expander
#(
  parameter HAS_EVA    = 1,
  parameter HAS_EVB    = 1,
  parameter HAS_SPP    = 1,
  parameter HAS_SCI    = 1,
  parameter HAS_CAN    = 1,
  parameter HAS_EXT    = 1
)
(
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Peripheral request lines, level sensitive.
  input  wire        timer2_period_req,
  input  wire        timer2_compare_req,
  input  wire        timer2_underflow_req,
  input  wire        timer2_overflow_req,
  input  wire        timer4_period_req,
  input  wire        timer4_compare_req,
  input  wire        timer4_underflow_req,
  input  wire        timer4_overflow_req,
  input  wire        serial_port_req,
  input  wire        async_rx_req,
  input  wire        async_tx_req,
  input  wire        can_mailbox_req,
  input  wire        can_error_req,
  input  wire        ext_pin_req_a,
  input  wire        ext_pin_req_b,
  // Per-peripheral high-priority mode selects.
  input  wire        sppHighPri,
  input  wire        sciHighPri,
  input  wire        canHighPri,
  input  wire        extHighPri,
  // CPU side: vector read strobe for one level and the level it targets.
  input  wire        vecRead,
  input  wire [2:0]  vecLevel,
  // CPU interrupt levels.
  output reg         cpu_level_one,
  output reg         cpu_level_three,
  output reg         cpu_level_five,
  output reg         cpu_level_six,
  // Vector answer, valid in the cycle after vecRead.
  output reg  [15:0] periph_vector_code,
  output reg  [15:0] cpuVectorAddr,
  output reg         vecValid,
  // Request and acknowledge register groups 0, 1 and 2.
  output reg  [15:0] periph_request_regs0,
  output reg  [15:0] periph_request_regs1,
  output reg  [15:0] periph_request_regs2,
  output reg  [15:0] periph_ack_regs0,
  output reg  [15:0] periph_ack_regs1,
  output reg  [15:0] periph_ack_regs2
);

  localparam NS = `NUM_SRC;

  // --------------------------------------------------------------------------
  // Source table helpers.
  // --------------------------------------------------------------------------
  // Vector code of a slot; timer slots step by one from their base.
  function [15:0] slotVector;
    input [4:0] s;
    begin
      if (s <= 5'd3)
        slotVector = `VEC_T2_PERIOD + {11'h000, s};
      else if (s <= 5'd7)
        slotVector = `VEC_T4_PERIOD + {11'h000, s - 5'd4};
      else if (s == `SLOT_SPP)
        slotVector = `VEC_SPP;
      else if (s == `SLOT_ARX)
        slotVector = `VEC_ARX;
      else if (s == `SLOT_ATX)
        slotVector = `VEC_ATX;
      else if (s == `SLOT_CAN_MB)
        slotVector = `VEC_CAN_MB;
      else if (s == `SLOT_CAN_ERR)
        slotVector = `VEC_CAN_ERR;
      else if (s == `SLOT_EXT_A)
        slotVector = `VEC_EXT_A;
      else if (s == `SLOT_EXT_B)
        slotVector = `VEC_EXT_B;
      else
        slotVector = `VEC_PHANTOM;
    end
  endfunction

  // Low-priority bit position of a slot inside its group.
  function [3:0] slotBit;
    input [4:0] s;
    begin
      if (s <= 5'd3)
        slotBit = `BIT_T2_PERIOD + s[3:0];
      else if (s <= 5'd7)
        slotBit = `BIT_T4_PERIOD + (s[3:0] - 4'h4);
      else if (s == `SLOT_SPP)
        slotBit = `BIT_SPP;
      else if (s == `SLOT_ARX)
        slotBit = `BIT_ARX;
      else if (s == `SLOT_ATX)
        slotBit = `BIT_ATX;
      else if (s == `SLOT_CAN_MB)
        slotBit = `BIT_CAN_MB;
      else if (s == `SLOT_CAN_ERR)
        slotBit = `BIT_CAN_ERR;
      else if (s == `SLOT_EXT_A)
        slotBit = `BIT_EXT_A;
      else
        slotBit = `BIT_EXT_B;
    end
  endfunction

  // Group-0 bit of a slot when its peripheral is in high-priority mode.
  function [3:0] slotHpBit;
    input [4:0] s;
    begin
      if (s == `SLOT_SPP)
        slotHpBit = `BIT_HP_SPP;
      else if (s == `SLOT_ARX)
        slotHpBit = `BIT_HP_ARX;
      else if (s == `SLOT_ATX)
        slotHpBit = `BIT_HP_ATX;
      else if (s == `SLOT_CAN_MB)
        slotHpBit = `BIT_HP_CAN_MB;
      else if (s == `SLOT_CAN_ERR)
        slotHpBit = `BIT_HP_CAN_ERR;
      else if (s == `SLOT_EXT_A)
        slotHpBit = `BIT_HP_EXT_A;
      else
        slotHpBit = `BIT_HP_EXT_B;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Raw requests, masked by device variant.
  // --------------------------------------------------------------------------
  wire [NS-1:0] rawReq;
  wire [NS-1:0] present;
  wire [NS-1:0] hpSel;

  assign rawReq = {2'b00, ext_pin_req_b, ext_pin_req_a, can_error_req, can_mailbox_req,
                   async_tx_req, async_rx_req, serial_port_req,
                   timer4_overflow_req, timer4_underflow_req, timer4_compare_req,
                   timer4_period_req, timer2_overflow_req, timer2_underflow_req,
                   timer2_compare_req, timer2_period_req};
  // Absent peripherals and the two spare slots never request.
  assign present = {2'b00, {2{HAS_EXT != 0}}, {2{HAS_CAN != 0}}, {2{HAS_SCI != 0}},
                    (HAS_SPP != 0), {4{HAS_EVB != 0}}, {4{HAS_EVA != 0}}};
  assign hpSel   = {2'b00, {2{extHighPri}}, {2{canHighPri}}, {2{sciHighPri}},
                    sppHighPri, 8'h00};

  reg  [NS-1:0] pend_r;
  wire [NS-1:0] pend_nxt;
  assign pend_nxt = rawReq & present;

  // --------------------------------------------------------------------------
  // Level split and request register images.
  // --------------------------------------------------------------------------
  wire [NS-1:0] lvl1Req;
  wire [NS-1:0] lvl3Req;
  wire [NS-1:0] lvl5Req;
  wire [NS-1:0] lvl6Req;

  assign lvl1Req = pend_r & hpSel;
  assign lvl3Req = pend_r & {9'h000, 8'hFF};
  assign lvl5Req = pend_r & ~hpSel & {4'h0, 5'h1F, 8'h00};
  assign lvl6Req = pend_r & ~hpSel & {2'b00, 2'b11, 13'h0000};

  reg [15:0] grp0Nxt;
  reg [15:0] grp1Nxt;
  reg [15:0] grp2Nxt;
  integer i;

  always @*
  begin
    grp0Nxt = 16'h0000;
    grp1Nxt = 16'h0000;
    grp2Nxt = 16'h0000;
    for (i = 0; i < NS - 2; i = i + 1)
    begin
      if (lvl1Req[i])
        grp0Nxt[slotHpBit(i[4:0])] = 1'b1;
      else if (pend_r[i] && i >= 4 && i <= 7)
        grp2Nxt[slotBit(i[4:0])] = 1'b1;
      else if (pend_r[i])
        grp1Nxt[slotBit(i[4:0])] = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Per-level winner selection.
  // --------------------------------------------------------------------------
  wire [3:0] lvlAny;
  wire [4:0] lvlWin [0:3];
  wire [NS-1:0] lvlReq [0:3];

  assign lvlReq[0] = {2'b00, lvl1Req[12:8], lvl1Req[14:13], 8'h00};
  assign lvlReq[1] = lvl3Req;
  assign lvlReq[2] = lvl5Req;
  assign lvlReq[3] = lvl6Req;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : pick
      prio_pick #(.N(NS), .IW(5)) u_pick
      (
        .reqVec (lvlReq[g]),
        .anyReq (lvlAny[g]),
        .winIdx (lvlWin[g])
      );
    end
  endgenerate

  // Level code from the CPU: 1, 3, 5 or 6; anything else is not a peripheral level.
  reg [1:0] selLvl;
  reg       selOk;
  reg [15:0] selAddr;

  always @*
  begin
    selLvl  = 2'd0;
    selOk   = 1'b1;
    selAddr = `ADDR_LEVEL_ONE;
    if (vecLevel == 3'd1)
    begin
      selLvl  = 2'd0;
      selAddr = `ADDR_LEVEL_ONE;
    end
    else if (vecLevel == 3'd3)
    begin
      selLvl  = 2'd1;
      selAddr = `ADDR_LEVEL_THREE;
    end
    else if (vecLevel == 3'd5)
    begin
      selLvl  = 2'd2;
      selAddr = `ADDR_LEVEL_FIVE;
    end
    else if (vecLevel == 3'd6)
    begin
      selLvl  = 2'd3;
      selAddr = `ADDR_LEVEL_SIX;
    end
    else
    begin
      // Software-only slots have no peripheral source behind them.
      selOk   = 1'b0;
      selAddr = 16'h0000;
    end
  end

  // Level one ranks the external pins ahead of the other high-priority sources,
  // so its picker index is mapped back to the source slot here.
  wire [4:0] lvl1Slot;
  wire [4:0] winSlot;

  assign lvl1Slot = (lvlWin[0] <= 5'd9) ? lvlWin[0] + 5'd5 : lvlWin[0] - 5'd2;
  assign winSlot  = (selLvl == 2'd0) ? lvl1Slot : lvlWin[selLvl];

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pend_r               <= {NS{1'b0}};
      cpu_level_one        <= 1'b0;
      cpu_level_three      <= 1'b0;
      cpu_level_five       <= 1'b0;
      cpu_level_six        <= 1'b0;
      periph_vector_code   <= `VEC_PHANTOM;
      cpuVectorAddr        <= 16'h0000;
      vecValid             <= 1'b0;
      periph_request_regs0 <= 16'h0000;
      periph_request_regs1 <= 16'h0000;
      periph_request_regs2 <= 16'h0000;
      periph_ack_regs0     <= 16'h0000;
      periph_ack_regs1     <= 16'h0000;
      periph_ack_regs2     <= 16'h0000;
    end
    else
    begin
      pend_r               <= pend_nxt;
      cpu_level_one        <= lvlAny[0];
      cpu_level_three      <= lvlAny[1];
      cpu_level_five       <= lvlAny[2];
      cpu_level_six        <= lvlAny[3];
      periph_request_regs0 <= grp0Nxt;
      periph_request_regs1 <= grp1Nxt;
      periph_request_regs2 <= grp2Nxt;
      vecValid             <= vecRead;
      periph_ack_regs0     <= 16'h0000;
      periph_ack_regs1     <= 16'h0000;
      periph_ack_regs2     <= 16'h0000;
      if (vecRead)
      begin
        cpuVectorAddr <= selAddr;
        if (selOk && lvlAny[selLvl])
        begin
          periph_vector_code <= slotVector(winSlot);
          if (selLvl == 2'd0)
            periph_ack_regs0[slotHpBit(winSlot)] <= 1'b1;
          else if (winSlot >= 5'd4 && winSlot <= 5'd7)
            periph_ack_regs2[slotBit(winSlot)] <= 1'b1;
          else
            periph_ack_regs1[slotBit(winSlot)] <= 1'b1;
        end
        else
          periph_vector_code <= `VEC_PHANTOM;
      end
    end
  end

endmodule // periph_interrupt_expander

// File: bench/periph_intx_checker.sv
`timescale 1ns/100ps
module periph_intx_checker
(
  // Clock and reset.
  input wire        core_clk,
  input wire        rst_n,
  // Watched inputs.
  input wire        timer2_period_req,
  input wire        ext_pin_req_a,
  input wire        extHighPri,
  input wire        vecRead,
  input wire [2:0]  vecLevel,
  // Watched outputs.
  input wire        cpu_level_three,
  input wire        cpu_level_six,
  input wire [15:0] periph_vector_code,
  input wire [15:0] cpuVectorAddr,
  input wire [15:0] periph_request_regs0,
  input wire [15:0] periph_request_regs1,
  input wire [15:0] periph_request_regs2,
  input wire [15:0] periph_ack_regs0,
  input wire [15:0] periph_ack_regs1,
  input wire [15:0] periph_ack_regs2
);
  wire [15:0] expAddr;
  assign expAddr = (vecLevel == 3'h1) ? 16'h0002 : (vecLevel == 3'h3) ? 16'h0006 :
                   (vecLevel == 3'h5) ? 16'h000A : (vecLevel == 3'h6) ? 16'h000C : 16'h0000;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_t2_held;
    timer2_period_req [*2];
  endsequence
  sequence s_hp_ext;
    (ext_pin_req_a && extHighPri) [*2];
  endsequence
  property p_t2_lag;
    s_t2_held |=> periph_request_regs1[0];
  endproperty
  a_t2_lag: assert property (p_t2_lag) else $error("timer2 period image missing");
  property p_hp_route;
    s_hp_ext |=> periph_request_regs0[2] && !periph_request_regs1[13];
  endproperty
  a_hp_route: assert property (p_hp_route) else $error("high priority route wrong");
  property p_t2_vec;
    vecRead && vecLevel == 3'h3 && periph_request_regs1[0]
      |=> periph_vector_code == 16'h002B && periph_ack_regs1 == 16'h0001;
  endproperty
  a_t2_vec: assert property (p_t2_vec) else $error("level three winner wrong");
  property p_l5_vec;
    vecRead && vecLevel == 3'h5 && periph_request_regs1[7] |=> periph_vector_code == 16'h0005;
  endproperty
  a_l5_vec: assert property (p_l5_vec) else $error("level five winner wrong");
  property p_phantom;
    vecRead && expAddr == 16'h0000
      |=> periph_vector_code == 16'h0000 && periph_ack_regs0 == 16'h0000
          && periph_ack_regs1 == 16'h0000 && periph_ack_regs2 == 16'h0000;
  endproperty
  a_phantom: assert property (p_phantom) else $error("software level answered");
  property p_addr;
    vecRead |=> cpuVectorAddr == $past(expAddr);
  endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_level3;
    cpu_level_three == (|periph_request_regs1[3:0] || |periph_request_regs2[11:8]);
  endproperty
  a_level3: assert property (p_level3) else $error("level three mismatch");
  property p_level6;
    cpu_level_six == |periph_request_regs1[14:13];
  endproperty
  a_level6: assert property (p_level6) else $error("level six mismatch");
  property p_unused_bits;
    periph_request_regs1[15] == 1'h0 && periph_request_regs1[12] == 1'h0
      && periph_request_regs1[6:4] == 3'h0 && periph_request_regs2[7:0] == 8'h00
      && periph_request_regs2[15:12] == 4'h0 && periph_request_regs0[1:0] == 2'h0
      && periph_request_regs0[15:9] == 7'h00;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused bit set");
endmodule // periph_intx_checker

bind periph_interrupt_expander periph_intx_checker i_periph_intx_checker
(
  .core_clk(core_clk), .rst_n(rst_n), .timer2_period_req(timer2_period_req),
  .ext_pin_req_a(ext_pin_req_a), .extHighPri(extHighPri), .vecRead(vecRead),
  .vecLevel(vecLevel), .cpu_level_three(cpu_level_three), .cpu_level_six(cpu_level_six),
  .periph_vector_code(periph_vector_code), .cpuVectorAddr(cpuVectorAddr),
  .periph_request_regs0(periph_request_regs0), .periph_request_regs1(periph_request_regs1),
  .periph_request_regs2(periph_request_regs2), .periph_ack_regs0(periph_ack_regs0),
  .periph_ack_regs1(periph_ack_regs1), .periph_ack_regs2(periph_ack_regs2)
);

// File: bench/cpu_vector_model.sv
`timescale 1ns/100ps
module cpu_vector_model
(
  // Clock.
  input  wire       core_clk,
  // Vector read strobe and level.
  output reg        vecRead,
  output reg  [2:0] vecLevel
);
  initial
  begin
    vecRead = 1'h0;
    vecLevel = 3'h0;
  end
  // Holds the strobe over one rising edge; the idle level is scrambled so it is never trusted.
  task read(input [2:0] lv);
    begin
      @(negedge core_clk);
      vecRead = 1'h1;
      vecLevel = lv;
      @(negedge core_clk);
      vecRead = 1'h0;
      vecLevel = ~lv;
    end
  endtask
endmodule // cpu_vector_model

// File: bench/peripheral_interrupt_expander_test.sv
`timescale 1ns/100ps
module peripheral_interrupt_expander_test;
  reg         core_clk;
  reg         rst_n;
  reg  [14:0] reqs;
  reg  [3:0]  hp;
  integer     errors;
  integer     checks_done;
  integer     i;
  wire        vecRead;
  wire [2:0]  vecLevel;
  wire        lvOne, lvThree, lvFive, lvSix, vecValid;
  wire [15:0] code, addr, rq0, rq1, rq2, ak0, ak1, ak2;
  wire        pLvThree, pLvFive;
  wire [15:0] pCode, pRq1, pRq2;
  function [15:0] low_code(input integer k);
    begin
      case (k)
        0: low_code = 16'h0005;
        1: low_code = 16'h0006;
        2: low_code = 16'h0007;
        3: low_code = 16'h0040;
        4: low_code = 16'h0041;
        5: low_code = 16'h0001;
        default: low_code = 16'h0011;
      endcase
    end
  endfunction
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  cpu_vector_model i_cpu_vector_model (.core_clk(core_clk), .vecRead(vecRead), .vecLevel(vecLevel));
  periph_interrupt_expander i_periph_interrupt_expander
  (
    .core_clk(core_clk), .rst_n(rst_n), .timer2_period_req(reqs[0]),
    .timer2_compare_req(reqs[1]), .timer2_underflow_req(reqs[2]), .timer2_overflow_req(reqs[3]),
    .timer4_period_req(reqs[4]), .timer4_compare_req(reqs[5]), .timer4_underflow_req(reqs[6]),
    .timer4_overflow_req(reqs[7]), .serial_port_req(reqs[8]), .async_rx_req(reqs[9]),
    .async_tx_req(reqs[10]), .can_mailbox_req(reqs[11]), .can_error_req(reqs[12]),
    .ext_pin_req_a(reqs[13]), .ext_pin_req_b(reqs[14]), .sppHighPri(hp[0]), .sciHighPri(hp[1]),
    .canHighPri(hp[2]), .extHighPri(hp[3]), .vecRead(vecRead), .vecLevel(vecLevel),
    .cpu_level_one(lvOne), .cpu_level_three(lvThree), .cpu_level_five(lvFive),
    .cpu_level_six(lvSix), .periph_vector_code(code), .cpuVectorAddr(addr), .vecValid(vecValid),
    .periph_request_regs0(rq0), .periph_request_regs1(rq1), .periph_request_regs2(rq2),
    .periph_ack_regs0(ak0), .periph_ack_regs1(ak1), .periph_ack_regs2(ak2)
  );
  // Variant without the second timer group, the async serial port and CAN.
  periph_interrupt_expander
  #(.HAS_EVB(0), .HAS_SCI(0), .HAS_CAN(0)) i_periph_interrupt_expander_part
  (
    .core_clk(core_clk), .rst_n(rst_n), .timer2_period_req(reqs[0]),
    .timer2_compare_req(reqs[1]), .timer2_underflow_req(reqs[2]), .timer2_overflow_req(reqs[3]),
    .timer4_period_req(reqs[4]), .timer4_compare_req(reqs[5]), .timer4_underflow_req(reqs[6]),
    .timer4_overflow_req(reqs[7]), .serial_port_req(reqs[8]), .async_rx_req(reqs[9]),
    .async_tx_req(reqs[10]), .can_mailbox_req(reqs[11]), .can_error_req(reqs[12]),
    .ext_pin_req_a(reqs[13]), .ext_pin_req_b(reqs[14]), .sppHighPri(hp[0]), .sciHighPri(hp[1]),
    .canHighPri(hp[2]), .extHighPri(hp[3]), .vecRead(vecRead), .vecLevel(vecLevel),
    .cpu_level_one(), .cpu_level_three(pLvThree), .cpu_level_five(pLvFive),
    .cpu_level_six(), .periph_vector_code(pCode), .cpuVectorAddr(), .vecValid(),
    .periph_request_regs0(), .periph_request_regs1(pRq1), .periph_request_regs2(pRq2),
    .periph_ack_regs0(), .periph_ack_regs1(), .periph_ack_regs2()
  );
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task settle;
    repeat (2) @(negedge core_clk);
  endtask
  // Raises one source alone, then reads its level and judges image, level, vector and ack.
  task one_src(input integer s, input integer g, input integer b, input [2:0] lv,
               input [15:0] exp);
    reg [15:0] img;
    reg        lvBit;
    begin
      reqs = 15'h0000;
      reqs[s] = 1'h1;
      settle;
      img = (g == 0) ? rq0 : (g == 1) ? rq1 : rq2;
      lvBit = (lv == 3'h1) ? lvOne : (lv == 3'h3) ? lvThree : (lv == 3'h5) ? lvFive : lvSix;
      check(img[b], 16'h0001);
      check(lvBit, 16'h0001);
      i_cpu_vector_model.read(lv);
      img = (g == 0) ? ak0 : (g == 1) ? ak1 : ak2;
      check(vecValid, 16'h0001);
      check(code, exp);
      check(img, 16'h0001 << b);
      check(addr, (lv == 3'h1) ? 16'h0002 : (lv == 3'h3) ? 16'h0006 :
                  (lv == 3'h5) ? 16'h000A : 16'h000C);
      reqs = 15'h0000;
      settle;
    end
  endtask
  task read_expect(input [2:0] lv, input [15:0] exp, input [15:0] expAck);
    begin
      i_cpu_vector_model.read(lv);
      check(code, exp);
      check(ak1, expAck);
    end
  endtask
  task t_reset;
    begin
      check({lvOne, lvThree, lvFive, lvSix}, 16'h0000);
      check(code, 16'h0000);
      $display("test reset done");
    end
  endtask
  task t_timers;
    begin
      for (i = 0; i < 8; i = i + 1)
        one_src(i, (i < 4) ? 1 : 2, (i < 4) ? i : i + 4, 3'h3,
                (i < 4) ? 16'h002B + i : 16'h0035 + i);
      $display("test timers done");
    end
  endtask
  task t_low_modes;
    begin
      hp = 4'h0;
      for (i = 8; i < 15; i = i + 1)
        one_src(i, 1, (i < 13) ? i - 1 : i, (i < 13) ? 3'h5 : 3'h6,
                low_code(i - 8));
      hp = 4'hF;
      for (i = 8; i < 15; i = i + 1)
        one_src(i, 0, (i < 13) ? i - 4 : i - 11, 3'h1, low_code(i - 8));
      hp = 4'h0;
      $display("test peripheral modes done");
    end
  endtask
  task t_priority;
    begin
      reqs = 15'h7FFF;
      settle;
      read_expect(3'h3, 16'h002B, 16'h0001);
      read_expect(3'h5, 16'h0005, 16'h0080);
      read_expect(3'h6, 16'h0001, 16'h2000);
      read_expect(3'h3, 16'h002B, 16'h0001);
      reqs = 15'h7EFE;
      settle;
      read_expect(3'h3, 16'h002C, 16'h0002);
      read_expect(3'h5, 16'h0006, 16'h0100);
      hp = 4'hF;
      reqs = 15'h7FFF;
      settle;
      read_expect(3'h1, 16'h0001, 16'h0000);
      check(ak0, 16'h0004);
      reqs = 15'h5FFF;
      settle;
      read_expect(3'h1, 16'h0011, 16'h0000);
      check(ak0, 16'h0008);
      hp = 4'h0;
      $display("test priority done");
    end
  endtask
  task t_phantom;
    begin
      reqs = 15'h0000;
      settle;
      read_expect(3'h3, 16'h0000, 16'h0000);
      read_expect(3'h1, 16'h0000, 16'h0000);
      reqs = 15'h7FFF;
      settle;
      for (i = 0; i < 8; i = i + 2)
      begin
        read_expect((i == 6) ? 3'h7 : i, 16'h0000, 16'h0000);
        check(addr, 16'h0000);
      end
      reqs = 15'h0000;
      $display("test phantom done");
    end
  endtask
  // The reduced variant must keep absent sources out of its images, levels and vectors.
  task t_absent;
    begin
      reqs = 15'h7FFF;
      settle;
      check(pRq1, 16'h608F);
      check(pRq2, 16'h0000);
      reqs = 15'h1EF0;
      settle;
      check({pLvThree, pLvFive}, 16'h0000);
      read_expect(3'h3, 16'h0039, 16'h0000);
      check(pCode, 16'h0000);
      read_expect(3'h5, 16'h0006, 16'h0100);
      check(pCode, 16'h0000);
      reqs = 15'h0000;
      settle;
      $display("test absent peripherals done");
    end
  endtask
  initial
  begin
    errors = 0;
    checks_done = 0;
    reqs = 15'h0000;
    hp = 4'h0;
    rst_n = 1'h0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'h1;
    @(negedge core_clk);
    t_reset;
    t_timers;
    t_low_modes;
    t_priority;
    t_phantom;
    t_absent;
    end_of_test;
  end
  initial
  begin
    #100000;
    errors = errors + 1;
    end_of_test;
  end
endmodule // peripheral_interrupt_expander_test
